//--- phy_regmap_pkg.sv
// constants, field layouts and state type of the transceiver reset and indicator block
// assumes a 100 MHz pclk and 16-bit registers, one per aligned 32-bit word
//
// How it works
// - three indicator pins, each picks one of several functions
// - default indicator functions follow the strapped three-bit operating mode
// - software picks indicator functions through indicator_config_one at 18h
// - strap sampled low makes that indicator drive active high
// - strap sampled high makes that indicator drive active low
// - rgmii-to-sgmii bridge with forced speed shows no link indication
// - in bridge modes activity indication is taken from the rgmii side
// - gigabit converter link shows only a 1000M copper link
// - 100M converter link shows only a 100M copper link
// - gigabit converter lets copper negotiation fall back to 100M only for one cycle after straps latch
// - reset pulse of 1us reloads all defaults and re-latches straps
// - bit 15 of basic_mode_control resets only the standard registers
// - bit 15 of global_control resets everything but keeps latched straps
// - bit 14 of global_control restarts circuits, register contents kept
// - fiber modes steer standard offsets onto the separate fiber register set
package phy_regmap_pkg;

  // ****************************************
  // register offsets (word index, byte address is four times)
  // ****************************************
  localparam int NREG = 64;
  localparam logic [5:0] OFS_BMC = 6'h00;
  localparam logic [5:0] OFS_BMS = 6'h01;
  localparam logic [5:0] OFS_IDH = 6'h02;
  localparam logic [5:0] OFS_IDL = 6'h03;
  localparam logic [5:0] OFS_AUTONEG_ADVERTISE = 6'h04;
  localparam logic [5:0] OFS_LPA = 6'h05;
  localparam logic [5:0] OFS_ANX = 6'h06;
  localparam logic [5:0] OFS_NPT = 6'h07;
  localparam logic [5:0] OFS_LNP = 6'h08;
  localparam logic [5:0] OFS_CFG1 = 6'h09;
  localparam logic [5:0] OFS_ST1 = 6'h0a;
  localparam logic [5:0] OFS_IAC = 6'h0d;
  localparam logic [5:0] OFS_IAV = 6'h0e;
  localparam logic [5:0] OFS_GCS = 6'h0f;
  localparam logic [5:0] OFS_TCTL = 6'h10;
  localparam logic [5:0] OFS_TST = 6'h11;
  localparam logic [5:0] OFS_MASK = 6'h12;
  localparam logic [5:0] OFS_FLAGS = 6'h13;
  localparam logic [5:0] OFS_CFG2 = 6'h14;
  localparam logic [5:0] OFS_REC = 6'h15;
  localparam logic [5:0] OFS_BIST = 6'h16;
  localparam logic [5:0] OFS_ST2 = 6'h17;
  localparam logic [5:0] OFS_IND1 = 6'h18;
  localparam logic [5:0] OFS_IND2 = 6'h19;
  localparam logic [5:0] OFS_IND3 = 6'h1a;
  localparam logic [5:0] OFS_CFG4 = 6'h1e;
  localparam logic [5:0] OFS_GCTL = 6'h1f;
  localparam logic [5:0] OFS_TCC = 6'h25;
  localparam logic [5:0] OFS_ECC = 6'h2c;
  localparam logic [5:0] OFS_FLD = 6'h2d;
  localparam logic [5:0] OFS_FLT = 6'h2e;
  localparam logic [5:0] OFS_CFG3 = 6'h31;
  localparam logic [5:0] OFS_RG1 = 6'h32;
  localparam logic [5:0] OFS_RG2 = 6'h33;
  localparam logic [5:0] OFS_SGS = 6'h37;
  localparam logic [5:0] OFS_PRC = 6'h39;
  localparam logic [5:0] OFS_PRB = 6'h3a;
  localparam logic [5:0] FIB_SPAN = 6'h10;

  // ****************************************
  // field positions
  // ****************************************
  localparam int RST_BIT = 15;
  localparam int RSTRT_BIT = 14;
  localparam int BMS_LINK_BIT = 2;
  localparam int TS_LINK_BIT = 10;
  localparam int TS_SPD_MSB = 15;
  localparam int EV_LINK = 0;
  localparam int EV_SPD = 1;
  localparam int EV_DONE = 2;
  localparam int IND_W = 4;

  // ****************************************
  // operating modes, speeds, indicator functions, defaults
  // ****************************************
  localparam logic [2:0] MODE_COPPER = 3'h0;
  localparam logic [2:0] MODE_F1000 = 3'h1;
  localparam logic [2:0] MODE_F100 = 3'h2;
  localparam logic [2:0] MODE_BR_R2S = 3'h3;
  localparam logic [2:0] MODE_MC1000 = 3'h4;
  localparam logic [2:0] MODE_MC100 = 3'h5;
  localparam logic [2:0] MODE_BR_S2R = 3'h6;
  localparam logic [1:0] SPD_100 = 2'h1;
  localparam logic [1:0] SPD_1000 = 2'h2;
  localparam logic [3:0] IND_LINK = 4'h0;
  localparam logic [3:0] IND_ACT = 4'h1;
  localparam logic [3:0] IND_TX = 4'h2;
  localparam logic [3:0] IND_RX = 4'h3;
  localparam logic [3:0] IND_L1000 = 4'h4;
  localparam logic [3:0] IND_L100 = 4'h5;
  localparam logic [3:0] IND_ON = 4'h6;
  localparam logic [15:0] IND_DEF_CU = 16'h0410;
  localparam logic [15:0] IND_DEF_BR = 16'h0032;
  localparam logic [15:0] IND_DEF_MC = 16'h0710;
  localparam logic [15:0] ID_HIGH = 16'h1234; // arbitrary identity value
  localparam logic [15:0] ID_LOW = 16'h5678; // arbitrary identity value
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] RST_CYCLES = 8'h10;

  // ****************************************
  // block state
  // ****************************************
  typedef struct packed {
    logic [NREG-1:0][15:0] regs;
    logic [15:0][15:0] fib;
    logic [15:0] flags;
    logic [2:0] pol;
    logic [2:0] mode;
    logic strap_wait;
    logic [CNT_W-1:0] std_cnt;
    logic [CNT_W-1:0] glb_cnt;
    logic [CNT_W-1:0] rs_cnt;
    logic link;
    logic [1:0] spd;
    logic [2:0] pins;
    logic [2:0] oe;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic restart;
    logic core_rst;
    logic fallback;
  } st_s;

endpackage

//--- phy_reset_led_regmap.sv
// apb register bank with reset control and strap-polarised indicator drivers
// assumes synchronous inputs on pclk and a standard apb master
`timescale 1ns/10ps
module phy_reset_led_regmap
  import phy_regmap_pkg::*;
(
  input wire logic pclk, // 100 MHz bus clock
  input wire logic presetn, // async reset, low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic [2:0] strap_ind, // indicator pin levels seen as straps
  input wire logic [2:0] strapped_operating_mode, // operating mode strap
  input wire logic link_up, // copper link state
  input wire logic [1:0] link_speed, // current link speed
  input wire logic forced_speed, // speed forced, not negotiated
  input wire logic cu_tx_act, // media side transmit activity
  input wire logic cu_rx_act, // media side receive activity
  input wire logic rgmii_tx_act, // rgmii side transmit activity
  input wire logic rgmii_rx_act, // rgmii side receive activity
  output logic indicator_pin_zero, // indicator drive 0
  output logic indicator_pin_one, // indicator drive 1
  output logic indicator_pin_two, // indicator drive 2
  output logic [2:0] indicator_oe, // indicator output enables
  output logic irq, // level interrupt
  output logic transceiver_restart, // restart pulse to circuits
  output logic core_reset, // global reset to circuits
  output logic fallback_100_en // copper negotiation may fall to 100M
);

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic is_listed(input logic [5:0] a);
    case (a)
      OFS_BMC, OFS_BMS, OFS_IDH, OFS_IDL, OFS_AUTONEG_ADVERTISE, OFS_LPA, OFS_ANX, OFS_NPT,
      OFS_LNP, OFS_CFG1, OFS_ST1, OFS_IAC, OFS_IAV, OFS_GCS, OFS_TCTL, OFS_TST,
      OFS_MASK, OFS_FLAGS, OFS_CFG2, OFS_REC, OFS_BIST, OFS_ST2, OFS_IND1,
      OFS_IND2, OFS_IND3, OFS_CFG4, OFS_GCTL, OFS_TCC, OFS_ECC, OFS_FLD,
      OFS_FLT, OFS_CFG3, OFS_RG1, OFS_RG2, OFS_SGS, OFS_PRC, OFS_PRB: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic is_writable(input logic [5:0] a);
    case (a)
      OFS_BMC, OFS_AUTONEG_ADVERTISE, OFS_NPT, OFS_CFG1, OFS_IAC, OFS_IAV, OFS_TCTL, OFS_MASK,
      OFS_CFG2, OFS_BIST, OFS_IND1, OFS_IND2, OFS_IND3, OFS_CFG4, OFS_GCTL,
      OFS_TCC, OFS_ECC, OFS_FLD, OFS_FLT, OFS_CFG3, OFS_RG1, OFS_RG2,
      OFS_PRC: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // indicator defaults per strapped mode
  function automatic logic [15:0] ind_default(input logic [2:0] m);
    case (m)
      MODE_BR_R2S, MODE_BR_S2R: return IND_DEF_BR;
      MODE_MC1000, MODE_MC100: return IND_DEF_MC;
      default: return IND_DEF_CU;
    endcase
  endfunction

  function automatic logic [15:0] reg_default(input logic [5:0] a, input logic [2:0] m);
    return (a == OFS_IND1) ? ind_default(m) : 16'h0000;
  endfunction

  // one indicator function evaluated against mode and live status
  function automatic logic ind_on(input logic [3:0] code, input logic [2:0] m,
                                  input logic lk, input logic [1:0] sp, input logic fs,
                                  input logic tx, input logic rx);
    logic lk_ok;
    case (m)
      MODE_MC1000: lk_ok = lk && (sp == SPD_1000);
      MODE_MC100: lk_ok = lk && (sp == SPD_100);
      MODE_BR_R2S: lk_ok = lk && !fs;
      default: lk_ok = lk;
    endcase
    case (code)
      IND_LINK: return lk_ok;
      IND_ACT: return tx | rx;
      IND_TX: return tx;
      IND_RX: return rx;
      IND_L1000: return lk_ok && (sp == SPD_1000);
      IND_L100: return lk_ok && (sp == SPD_100);
      IND_ON: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // ****************************************
  // bus decode
  // ****************************************
  st_s st_q;
  st_s st_d;
  logic [5:0] widx;
  logic [15:0] wd;
  logic fiber;
  logic addr_ok;
  logic acc;
  logic wr_en;
  logic irq_src;

  assign widx = paddr[7:2];
  assign wd = pwdata[15:0];
  assign fiber = (st_q.mode == MODE_F1000) || (st_q.mode == MODE_F100);
  assign addr_ok = (paddr[1:0] == 2'b00) && is_listed(widx);
  assign acc = psel && penable && !st_q.pready;
  // writes take effect on the edge where pready is seen high
  assign wr_en = psel && penable && st_q.pready && pwrite && addr_ok
                 && (st_q.glb_cnt == '0) && !st_q.strap_wait;
  assign irq_src = |(st_q.flags & st_q.regs[OFS_MASK]);

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [15:0] rv;
    logic [2:0] ev;
    logic tx_s;
    logic rx_s;
    rv = 16'h0000;
    ev = 3'b000;
    tx_s = 1'b0;
    rx_s = 1'b0;
    st_d = st_q;
    // read mux, fiber bank overlays the standard offsets
    if (fiber && (widx < FIB_SPAN)) begin
      rv = st_q.fib[widx[3:0]];
    end else begin
      rv = st_q.regs[widx];
    end
    if (widx == OFS_BMC) begin
      rv[RST_BIT] = (st_q.std_cnt != '0);
    end else if (widx == OFS_BMS) begin
      rv[BMS_LINK_BIT] = st_q.link;
    end else if (widx == OFS_IDH) begin
      rv = ID_HIGH;
    end else if (widx == OFS_IDL) begin
      rv = ID_LOW;
    end else if (widx == OFS_TST) begin
      rv[TS_LINK_BIT] = st_q.link;
      rv[TS_SPD_MSB -: 2] = st_q.spd;
    end else if (widx == OFS_FLAGS) begin
      rv = st_q.flags;
    end else if (widx == OFS_GCTL) begin
      rv[RST_BIT] = (st_q.glb_cnt != '0);
      rv[RSTRT_BIT] = (st_q.rs_cnt != '0);
    end
    // apb answer one cycle after the access phase opens
    st_d.pready = acc;
    st_d.pslverr = acc && !addr_ok;
    st_d.prdata = (acc && addr_ok && !pwrite) ? {16'h0000, rv} : 32'h0000_0000;
    // reset and restart timers count down, done raises an event
    if (st_q.std_cnt != '0) begin
      st_d.std_cnt = st_q.std_cnt - 1'b1;
    end
    if (st_q.glb_cnt != '0) begin
      st_d.glb_cnt = st_q.glb_cnt - 1'b1;
    end
    if (st_q.rs_cnt != '0) begin
      st_d.rs_cnt = st_q.rs_cnt - 1'b1;
    end
    ev[EV_DONE] = (st_q.std_cnt == 8'h01) || (st_q.glb_cnt == 8'h01)
                  || (st_q.rs_cnt == 8'h01);
    // register writes
    if (wr_en) begin
      if (widx == OFS_FLAGS) begin
        st_d.flags = st_q.flags & ~wd;
      end else if (is_writable(widx)) begin
        if (fiber && (widx < FIB_SPAN)) begin
          st_d.fib[widx[3:0]] = wd;
        end else begin
          st_d.regs[widx] = wd;
        end
      end
      if ((widx == OFS_BMC) && wd[RST_BIT]) begin
        st_d.std_cnt = RST_CYCLES;
      end
      if ((widx == OFS_GCTL) && wd[RST_BIT]) begin
        st_d.glb_cnt = RST_CYCLES;
      end
      if ((widx == OFS_GCTL) && wd[RSTRT_BIT]) begin
        st_d.rs_cnt = RST_CYCLES;
      end
    end
    // standard registers of both banks held at defaults
    if (st_q.std_cnt != '0) begin
      for (int i = 0; i < 16; i++) begin
        st_d.regs[i] = reg_default(6'(i), st_q.mode);
        st_d.fib[i] = 16'h0000;
      end
    end
    // global reset holds every register, straps stay latched
    if (st_q.glb_cnt != '0) begin
      for (int i = 0; i < NREG; i++) begin
        st_d.regs[i] = reg_default(6'(i), st_q.mode);
      end
      st_d.fib = '0;
      st_d.flags = 16'h0000;
    end
    // status events, a set beats a clear in the same cycle
    st_d.link = link_up;
    st_d.spd = link_speed;
    ev[EV_LINK] = (link_up != st_q.link);
    ev[EV_SPD] = (link_speed != st_q.spd);
    st_d.flags = st_d.flags | {13'h0000, ev};
    st_d.irq = irq_src;
    st_d.core_rst = (st_d.glb_cnt != '0);
    st_d.restart = (st_d.rs_cnt != '0);
    st_d.fallback = (st_q.mode != MODE_MC1000);
    // straps caught once after reset release, then pins driven
    if (st_q.strap_wait) begin
      st_d.strap_wait = 1'b0;
      st_d.pol = strap_ind;
      st_d.mode = strapped_operating_mode;
      for (int i = 0; i < NREG; i++) begin
        st_d.regs[i] = reg_default(6'(i), strapped_operating_mode);
      end
      st_d.pins = 3'b000;
      st_d.oe = 3'b000;
    end else begin
      st_d.oe = 3'b111;
      tx_s = (st_q.mode == MODE_BR_R2S || st_q.mode == MODE_BR_S2R) ? rgmii_tx_act
             : cu_tx_act;
      rx_s = (st_q.mode == MODE_BR_R2S || st_q.mode == MODE_BR_S2R) ? rgmii_rx_act
             : cu_rx_act;
      for (int i = 0; i < 3; i++) begin
        st_d.pins[i] = st_q.pol[i] ^ ind_on(st_q.regs[OFS_IND1][i*IND_W +: IND_W],
                                            st_q.mode, link_up, link_speed,
                                            forced_speed, tx_s, rx_s);
      end
    end
  end

  // ****************************************
  // state register, hardware reset reloads all
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
      st_q.strap_wait <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from flops
  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign indicator_pin_zero = st_q.pins[0];
  assign indicator_pin_one = st_q.pins[1];
  assign indicator_pin_two = st_q.pins[2];
  assign indicator_oe = st_q.oe;
  assign irq = st_q.irq;
  assign transceiver_restart = st_q.restart;
  assign core_reset = st_q.core_rst;
  assign fallback_100_en = st_q.fallback;

  // ****************************************
  // checks
  // ****************************************
  localparam int A_MAX = 24;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_busy_then_done;
    (st_q.std_cnt == RST_CYCLES) ##[1:A_MAX] (st_q.std_cnt == '0);
  endsequence
  property p_std_rst;
    wr_en && (widx == OFS_BMC) && wd[RST_BIT] |=> s_busy_then_done;
  endproperty
  a_std_rst: assert property (p_std_rst) else $error("std reset bit stuck");
  property p_std_only;
    (st_q.std_cnt != '0) && (st_q.glb_cnt == '0) && !wr_en |=> $stable(st_q.regs[OFS_IND1]);
  endproperty
  a_std_only: assert property (p_std_only) else $error("std reset hit ext reg");
  property p_glb;
    wr_en && (widx == OFS_GCTL) && wd[RST_BIT] |=> core_reset[*8] ##[1:A_MAX] !core_reset;
  endproperty
  a_glb: assert property (p_glb) else $error("global reset pulse wrong");
  property p_glb_keep;
    st_q.glb_cnt != '0 |=> $stable(st_q.pol) && $stable(st_q.mode);
  endproperty
  a_glb_keep: assert property (p_glb_keep) else $error("straps lost");
  property p_rs;
    wr_en && (widx == OFS_GCTL) && wd[RSTRT_BIT] |=> transceiver_restart[*8]
      ##[1:A_MAX] !transceiver_restart;
  endproperty
  a_rs: assert property (p_rs) else $error("restart pulse wrong");
  property p_ind_wr;
    wr_en && (widx == OFS_IND1) |=> st_q.regs[OFS_IND1] == $past(wd);
  endproperty
  a_ind_wr: assert property (p_ind_wr) else $error("indicator cfg not written");
  property p_pol_hi;
    !st_q.strap_wait && !st_q.pol[0] && (st_q.regs[OFS_IND1][3:0] == IND_ON)
      |=> indicator_pin_zero;
  endproperty
  a_pol_hi: assert property (p_pol_hi) else $error("active high drive wrong");
  property p_pol_lo;
    !st_q.strap_wait && st_q.pol[0] && (st_q.regs[OFS_IND1][3:0] == IND_ON)
      |=> !indicator_pin_zero;
  endproperty
  a_pol_lo: assert property (p_pol_lo) else $error("active low drive wrong");
  property p_mc_link;
    !st_q.strap_wait && (st_q.mode == MODE_MC1000) && (link_speed != SPD_1000)
      && (st_q.regs[OFS_IND1][3:0] == IND_LINK) |=> indicator_pin_zero == st_q.pol[0];
  endproperty
  a_mc_link: assert property (p_mc_link) else $error("link shown at wrong speed");
  property p_fb;
    !st_q.strap_wait && (st_q.mode == MODE_MC1000) |=> !fallback_100_en;
  endproperty
  a_fb: assert property (p_fb) else $error("100M fallback allowed");
  property p_strap;
    // sampled presetn keeps the release edge out, straps are caught one edge later
    st_q.strap_wait && presetn |=> !st_q.strap_wait && (st_q.pol == $past(strap_ind));
  endproperty
  a_strap: assert property (p_strap) else $error("straps not latched");
  property p_apb;
    acc |=> pready ##1 !pready;
  endproperty
  a_apb: assert property (p_apb) else $error("apb ready timing wrong");
  property p_irq;
    1'b1 |=> irq == $past(irq_src);
  endproperty
  a_irq: assert property (p_irq) else $error("irq not following flags");
  // drivers enabled once the straps are latched
  property p_oe;
    !st_q.strap_wait |=> indicator_oe == 3'h7;
  endproperty
  a_oe: assert property (p_oe) else $error("indicator drivers not enabled");
  // default indicator functions follow the latched mode
  property p_def;
    st_q.strap_wait && presetn
      |=> st_q.regs[OFS_IND1] == ind_default($past(strapped_operating_mode));
  endproperty
  a_def: assert property (p_def) else $error("indicator defaults wrong");
  // forced rgmii-to-sgmii bridge never shows link, bridges show rgmii activity
  property p_br_link;
    !st_q.strap_wait && (st_q.mode == MODE_BR_R2S) && forced_speed
      && (st_q.regs[OFS_IND1][3:0] == IND_LINK) |=> indicator_pin_zero == st_q.pol[0];
  endproperty
  a_br_link: assert property (p_br_link) else $error("link shown in forced bridge");
  property p_br_act;
    !st_q.strap_wait && ((st_q.mode == MODE_BR_R2S) || (st_q.mode == MODE_BR_S2R))
      && (st_q.regs[OFS_IND1][7:4] == IND_TX)
      |=> indicator_pin_one == (st_q.pol[1] ^ $past(rgmii_tx_act));
  endproperty
  a_br_act: assert property (p_br_act) else $error("bridge activity source wrong");
  property p_mc100;
    !st_q.strap_wait && (st_q.mode == MODE_MC100) && (link_speed != SPD_100)
      && (st_q.regs[OFS_IND1][3:0] == IND_LINK) |=> indicator_pin_zero == st_q.pol[0];
  endproperty
  a_mc100: assert property (p_mc100) else $error("link shown at wrong speed");
  // fiber writes land in the fiber bank, standard word untouched
  property p_fib;
    wr_en && fiber && (widx == OFS_AUTONEG_ADVERTISE) && (st_q.std_cnt == '0)
      |=> (st_q.fib[OFS_AUTONEG_ADVERTISE[3:0]] == $past(wd)) && $stable(st_q.regs[OFS_AUTONEG_ADVERTISE]);
  endproperty
  a_fib: assert property (p_fib) else $error("fiber bank not used");
  // refused addresses answer with an error and zero data
  property p_err;
    acc && !addr_ok |=> pslverr && (prdata == 32'h0000_0000);
  endproperty
  a_err: assert property (p_err) else $error("bad address not refused");

endmodule // phy_reset_led_regmap

//--- phy_host_model.sv
// host controller model: drives the reset pin and speaks apb to the block
// assumes the block answers within 50 cycles of the access phase
`timescale 1ns/10ps
module phy_host_model (
  input wire logic pclk, // bus clock
  output logic presetn, // reset pin drive, low
  output logic psel, // apb select
  output logic penable, // apb enable
  output logic pwrite, // apb write
  output logic [7:0] paddr, // apb byte address
  output logic [31:0] pwdata, // apb write data
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr // apb error
);
  logic [31:0] rdata;
  logic rerr;
  bit hung;

  // ****************************************
  // reset pin and apb transfers
  // ****************************************
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    hung = 1'b0;
  end

  // low pulse, then three edges so straps and drivers settle before use
  task automatic hw_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask

  // one transfer; request held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) hung = 1'b1;
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d; // released data does not keep its last value
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    xfer(1'b1, a, {16'h0000, d});
  endtask

  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0000_0000);
  endtask
endmodule // phy_host_model

//--- tb_phy_reset_led_regmap.sv
// self-checking bench of the reset, indicator and register block
// assumes the host model for apb and reset, straps and media levels from here
`timescale 1ns/10ps
module tb_phy_reset_led_regmap
  import phy_regmap_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0] strap_ind, mode, oe;
  logic link_up, forced_speed, ctx, crx, rtx, rrx;
  logic [1:0] link_speed;
  logic pin0, pin1, pin2, irq, restart, core_rst, fallback;
  int failures, total_checks, cyc;

  phy_host_model u_host_model (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  phy_reset_led_regmap u_phy_reset_led_regmap (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .strap_ind(strap_ind),
    .strapped_operating_mode(mode), .link_up(link_up), .link_speed(link_speed),
    .forced_speed(forced_speed), .cu_tx_act(ctx), .cu_rx_act(crx),
    .rgmii_tx_act(rtx), .rgmii_rx_act(rrx), .indicator_pin_zero(pin0),
    .indicator_pin_one(pin1), .indicator_pin_two(pin2), .indicator_oe(oe),
    .irq(irq), .transceiver_restart(restart), .core_reset(core_rst),
    .fallback_100_en(fallback));

  // ****************************************
  // clock, timeout and report
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic test_done();
    if (failures == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // hang guard, also trips when the host saw no ready
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000 || u_host_model.hung) begin
      failures++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // read back a register word and compare
  task automatic rdc(input logic [5:0] ix, input logic [15:0] exp);
    u_host_model.rd({ix, 2'b00});
    chk(u_host_model.rdata, {16'h0000, exp});
  endtask

  // poll a self-clearing bit until it drops
  task automatic poll(input logic [5:0] ix, input int b);
    int k;
    for (k = 0; k < 40; k++) begin
      u_host_model.rd({ix, 2'b00});
      if (u_host_model.rdata[b] === 1'b0) break;
    end
    chk({31'h0, u_host_model.rdata[b]}, 32'h0);
  endtask

  task automatic pins(input logic [2:0] exp);
    settle(3);
    chk({29'h0, pin2, pin1, pin0}, {29'h0, exp});
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    failures = 0;
    total_checks = 0;
    cyc = 0;
    strap_ind = 3'b101;
    mode = MODE_COPPER;
    {link_up, forced_speed, ctx, crx, rtx, rrx} = 6'h00;
    link_speed = 2'h0;
    u_host_model.hw_reset();
    chk({29'h0, oe}, 32'h7);
    rdc(OFS_IND1, IND_DEF_CU);
    rdc(OFS_IDH, ID_HIGH);
    pins(3'b101);
    u_host_model.wr({OFS_IND1, 2'b00}, 16'h0666);
    pins(3'b010);
    u_host_model.rd(8'h2c);
    chk({31'h0, u_host_model.rerr}, 32'h1);
    chk(u_host_model.rdata, 32'h0);
    u_host_model.wr(8'h61, 16'h0fff);
    rdc(OFS_IND1, 16'h0666);
    // standard reset, done event and interrupt
    u_host_model.wr({OFS_AUTONEG_ADVERTISE, 2'b00}, 16'h0de1);
    u_host_model.wr({OFS_BMC, 2'b00}, 16'h8000);
    u_host_model.rd({OFS_BMC, 2'b00});
    chk({31'h0, u_host_model.rdata[RST_BIT]}, 32'h1);
    poll(OFS_BMC, RST_BIT);
    rdc(OFS_AUTONEG_ADVERTISE, 16'h0000);
    rdc(OFS_IND1, 16'h0666);
    u_host_model.rd({OFS_FLAGS, 2'b00});
    chk({31'h0, u_host_model.rdata[EV_DONE]}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    u_host_model.wr({OFS_MASK, 2'b00}, 16'h0004);
    settle(2);
    chk({31'h0, irq}, 32'h1);
    u_host_model.wr({OFS_FLAGS, 2'b00}, 16'h0004);
    settle(2);
    chk({31'h0, irq}, 32'h0);
    // restart keeps registers
    u_host_model.wr({OFS_AUTONEG_ADVERTISE, 2'b00}, 16'h0de1);
    u_host_model.wr({OFS_GCTL, 2'b00}, 16'h4000);
    settle(2);
    chk({31'h0, restart}, 32'h1);
    poll(OFS_GCTL, RSTRT_BIT);
    chk({31'h0, restart}, 32'h0);
    rdc(OFS_AUTONEG_ADVERTISE, 16'h0de1);
    // global reset restores defaults, straps kept
    u_host_model.wr({OFS_GCTL, 2'b00}, 16'h8000);
    settle(2);
    chk({31'h0, core_rst}, 32'h1);
    poll(OFS_GCTL, RST_BIT);
    rdc(OFS_IND1, IND_DEF_CU);
    rdc(OFS_AUTONEG_ADVERTISE, 16'h0000);
    pins(3'b101);
    // both bridges, activity from the rgmii side, no link when forced in one
    strap_ind <= 3'h0;
    for (int j = 0; j < 2; j++) begin
      mode <= (j == 0) ? MODE_BR_R2S : MODE_BR_S2R;
      u_host_model.hw_reset();
      rdc(OFS_IND1, IND_DEF_BR);
      u_host_model.wr({OFS_IND1, 2'b00}, 16'h0320);
      @(posedge pclk);
      link_up <= 1'b1;
      link_speed <= SPD_1000;
      forced_speed <= 1'b1;
      rtx <= 1'b1;
      crx <= 1'b1;
      pins({2'h1, j == 1});
    end
    u_host_model.wr({OFS_IND1, 2'b00}, 16'h0776);
    pins(3'h1);
    // both converter modes: link shown only at the matching speed
    for (int i = 0; i < 2; i++) begin
      mode <= (i == 0) ? MODE_MC1000 : MODE_MC100;
      u_host_model.hw_reset();
      chk({31'h0, fallback}, {31'h0, i == 1});
      rdc(OFS_IND1, IND_DEF_MC);
      @(posedge pclk);
      link_speed <= SPD_1000;
      settle(3);
      chk({31'h0, pin0}, {31'h0, i == 0});
      link_speed <= SPD_100;
      settle(3);
      chk({31'h0, pin0}, {31'h0, i == 1});
    end
    // fiber modes steer the standard offsets to their own bank
    for (int k = 0; k < 2; k++) begin
      mode <= (k == 0) ? MODE_F1000 : MODE_F100;
      u_host_model.hw_reset();
      u_host_model.wr({OFS_AUTONEG_ADVERTISE, 2'b00}, 16'h0abc);
      rdc(OFS_AUTONEG_ADVERTISE, 16'h0abc);
    end
    test_done();
  end
endmodule // tb_phy_reset_led_regmap
